// File: rtl/mdm_mgmt.sv
`timescale 1ns/1ps
// Notes on behaviour
// - frame: 32 ones, start 01, opcode, phy, register, turnaround, 16 data, idle
// - read turnaround: released then device drives zero; write turnaround driven 1,0
// - phy address bit 2 low selects the standard phy register path
// - standard path ignores phy address bits 4 and 3
// - standard path has six 16-bit registers, indices 0 to 5
// - phy address bit 2 high selects the extended configuration path
// - extended path ignores phy address bits 1 and 0
// - extended index is phy bits 4:3 above the 5-bit register address
// - extended path reaches indices 0 to 127, separate from the six phy registers
// - extended read returns zero upper byte and register in low byte
// - extended write keeps only the low data byte
// - extended frames share framing, turnaround and timing with standard ones
module mdm_mgmt
  import mdm_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oen_o
);
  logic [1:0] mdc_sync_ff;
  logic [1:0] mdio_sync_ff;
  logic mdc_prev_ff;
  logic rise;
  mdm_state_e state_ff;
  logic [5:0] cnt_ff;
  logic [13:0] hdr_sh_ff;
  mdm_hdr_s hdr;
  logic [DATA_W-1:0] sh_ff;
  logic [DATA_W-1:0] phy_reg_ff [PHY_REG_CNT];
  logic [EXT_W-1:0] ext_reg_ff [EXT_REG_CNT];
  mdm_pin_s pin_ff;

  function automatic logic [EXT_IDX_W-1:0] ext_index(input mdm_hdr_s h);
    return {h.phy[4:3], h.reg_idx};
  endfunction

  // ext index 0..5 selects its own ext registers, separate from the phy registers
  function automatic logic [DATA_W-1:0] read_word(input mdm_hdr_s h);
    logic [EXT_IDX_W-1:0] i;
    i = ext_index(h);
    read_word = '0;
    if (h.phy[PATH_BIT]) begin
      read_word = {8'h00, ext_reg_ff[i]};
    end else if (h.reg_idx < ADDR_W'(PHY_REG_CNT)) begin
      read_word = phy_reg_ff[h.reg_idx[2:0]];
    end
  endfunction

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mdc_sync_ff <= 2'h0;
      mdio_sync_ff <= 2'h3;
      mdc_prev_ff <= 1'b0;
    end else begin
      mdc_sync_ff <= {mdc_sync_ff[0], mdc_i};
      mdio_sync_ff <= {mdio_sync_ff[0], mdio_i};
      mdc_prev_ff <= mdc_sync_ff[1];
    end
  end

  assign rise = mdc_sync_ff[1] & ~mdc_prev_ff;
  assign hdr = mdm_hdr_s'({hdr_sh_ff[11:0]});

  logic pre_full;
  logic hdr_last;
  logic hdr_good;
  logic rd_last;
  logic wr_last;
  assign pre_full = cnt_ff == 6'(PREAMBLE_LEN);
  assign hdr_last = state_ff == ST_HEADER && cnt_ff == 6'h0C;
  // last header bit not yet shifted: start bit sits at 11, opcode at 10:9
  assign hdr_good = hdr_sh_ff[11] == START_CODE[0] &&
      (hdr_sh_ff[10:9] == OP_READ || hdr_sh_ff[10:9] == OP_WRITE);
  assign rd_last = cnt_ff == 6'(DATA_W - 1);
  // write data state also swallows the second turnaround bit, so one rise more
  assign wr_last = cnt_ff == 6'(DATA_W);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_PREAMBLE;
    end else if (rise) begin
      unique case (state_ff)
        ST_PREAMBLE: begin
          // preamble shorter than 32 ones is rejected
          if (!mdio_sync_ff[1] && pre_full) begin
            state_ff <= ST_HEADER;
          end
        end
        ST_HEADER: begin
          if (hdr_last) begin
            state_ff <= hdr_good ? ST_TA : ST_PREAMBLE;
          end
        end
        ST_TA: begin
          state_ff <= (hdr.op == OP_READ) ? ST_RDATA : ST_WDATA;
        end
        ST_RDATA: begin
          if (rd_last) begin
            state_ff <= ST_PREAMBLE;
          end
        end
        ST_WDATA: begin
          if (wr_last) begin
            state_ff <= ST_PREAMBLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= 6'h00;
    end else if (rise) begin
      unique case (state_ff)
        ST_PREAMBLE: begin
          // ones count saturates so a long preamble is still fine
          if (!mdio_sync_ff[1]) begin
            cnt_ff <= 6'h00;
          end else if (!pre_full) begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_HEADER: begin
          if (hdr_last) begin
            cnt_ff <= 6'h00;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_TA: begin
          cnt_ff <= 6'h00;
        end
        ST_RDATA: begin
          if (rd_last) begin
            cnt_ff <= 6'h00;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_WDATA: begin
          if (wr_last) begin
            cnt_ff <= 6'h00;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hdr_sh_ff <= 14'h0000;
      sh_ff <= 16'h0000;
    end else if (rise) begin
      unique case (state_ff)
        ST_PREAMBLE: begin
          if (!mdio_sync_ff[1] && pre_full) begin
            hdr_sh_ff <= 14'h0000;
          end
        end
        ST_HEADER: begin
          hdr_sh_ff <= {hdr_sh_ff[12:0], mdio_sync_ff[1]};
        end
        ST_TA: begin
          sh_ff <= read_word(hdr);
        end
        ST_RDATA: begin
          sh_ff <= {sh_ff[DATA_W-2:0], 1'b0};
        end
        ST_WDATA: begin
          sh_ff <= {sh_ff[DATA_W-2:0], mdio_sync_ff[1]};
        end
      endcase
    end
  end

  // header state: the last bit in before ta is shifted while cnt is 12; ta first
  // bit arrives in ST_TA, second bit taken on entry to data states
  logic wr_done;
  assign wr_done = rise && state_ff == ST_WDATA && wr_last;
  logic [DATA_W-1:0] wr_word;
  assign wr_word = {sh_ff[DATA_W-2:0], mdio_sync_ff[1]};

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < PHY_REG_CNT; i++) begin
        phy_reg_ff[i] <= PHY_REG_RST;
      end
      for (int i = 0; i < EXT_REG_CNT; i++) begin
        ext_reg_ff[i] <= EXT_REG_RST;
      end
    end else if (wr_done) begin
      if (hdr.phy[PATH_BIT]) begin
        ext_reg_ff[ext_index(hdr)] <= wr_word[EXT_W-1:0];
      end else if (hdr.reg_idx < ADDR_W'(PHY_REG_CNT)) begin
        phy_reg_ff[hdr.reg_idx[2:0]] <= wr_word;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_ff <= '{dout: 1'b1, oen: 1'b1};
    end else if (rise) begin
      if (state_ff == ST_TA && hdr.op == OP_READ) begin
        pin_ff <= '{dout: 1'b0, oen: 1'b0};
      end else if (state_ff == ST_RDATA && cnt_ff != 6'(DATA_W - 1)) begin
        pin_ff <= '{dout: sh_ff[DATA_W-1], oen: 1'b0};
      end else if (state_ff == ST_RDATA) begin
        pin_ff <= '{dout: sh_ff[DATA_W-1], oen: 1'b0};
      end else begin
        pin_ff <= '{dout: 1'b1, oen: 1'b1};
      end
    end
  end

  assign mdio_o = pin_ff.dout;
  assign mdio_oen_o = pin_ff.oen;
endmodule

// File: rtl/mdm_pkg.sv
package mdm_pkg;
  localparam int PREAMBLE_LEN = 32;
  localparam int PHY_REG_CNT = 6;
  localparam int EXT_REG_CNT = 128;
  localparam int DATA_W = 16;
  localparam int EXT_W = 8;
  localparam int ADDR_W = 5;
  localparam int EXT_IDX_W = 7;
  localparam int PATH_BIT = 2;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [DATA_W-1:0] PHY_REG_RST = 16'h0000;
  localparam logic [EXT_W-1:0] EXT_REG_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_HEADER,
    ST_TA,
    ST_RDATA,
    ST_WDATA
  } mdm_state_e;

  typedef struct packed {
    logic [1:0] op;
    logic [ADDR_W-1:0] phy;
    logic [ADDR_W-1:0] reg_idx;
  } mdm_hdr_s;

  typedef struct packed {
    logic dout;
    logic oen;
  } mdm_pin_s;
endpackage

// File: verification/mdm_ctl.sv
`timescale 1ns/1ps
module mdm_ctl
  import mdm_pkg::*;
(
  output logic mdc,
  output logic dat,
  output logic en,
  input wire logic line
);
  initial {mdc, dat, en} = 3'h2;
  // link clock stands low between frames
  task automatic xfer(input mdm_hdr_s h, input logic [15:0] wd, output logic [15:0] q);
    logic [63:0] f;
    f = {{PREAMBLE_LEN{1'b1}}, START_CODE, h, 2'h2, wd};
    for (int i = 0; i < 64; i++) begin
      dat = f[63-i];
      en = h.op == OP_WRITE || i < 46;
      #300;
      if (i > 47) q[63-i] = line;
      mdc = 1'b1;
      #400;
      mdc = 1'b0;
      #100;
    end
    en = 1'b0;
  endtask
endmodule

// File: verification/mdm_mgmt_assertions.sv
`timescale 1ns/1ps
module mdm_mgmt_assertions (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oen_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  AST_TA: assert property ($fell(mdio_oen_o) |-> !mdio_o) else $error("ta");
  AST_LEN: assert property ($fell(mdio_oen_o) |-> ##134 !mdio_oen_o ##[1:4] mdio_oen_o)
    else $error("len");
  AST_REL: assert property ($rose(mdio_oen_o) |-> mdio_oen_o [*8]) else $error("rel");
  AST_GAP: assert property ($fell(mdio_oen_o) |-> $past(mdio_oen_o, 300))
    else $error("gap");
  AST_MIN: assert property ($rose(mdio_oen_o) |-> !$past(mdio_oen_o, 130))
    else $error("min");
  // sync latency puts every launch three or four clocks behind the link rise
  AST_OE: assert property ($changed(mdio_oen_o) |-> $past(mdc_i, 3) || $past(mdc_i, 4))
    else $error("oe");
  AST_BIT: assert property (!mdio_oen_o && $changed(mdio_o) |-> $past(mdc_i, 3) ||
    $past(mdc_i, 4)) else $error("bit");
  AST_HOLD: assert property ($changed(mdio_o) |=> $stable(mdio_o) [*6])
    else $error("hold");
endmodule
bind mdm_mgmt mdm_mgmt_assertions u_chk (.clock_i, .resetn_i, .mdc_i, .mdio_i, .mdio_o,
  .mdio_oen_o);

// File: verification/mdm_mgmt_tb.sv
`timescale 1ns/1ps
module mdm_mgmt_tb;
  import mdm_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mdc, dat, en, mdio_o, oen, line;
  logic [15:0] sr[PHY_REG_CNT];
  logic [7:0] er[EXT_REG_CNT];
  logic [15:0] d, q;
  mdm_hdr_s h;
  int n_errors = 0;
  int n_checks = 0;
  always #50 clock_i = ~clock_i;
  // released line shows the inverse so a silent device cannot pass
  assign line = !oen ? mdio_o : en ? dat : ~dat;
  mdm_ctl ml (.mdc, .dat, .en, .line);
  mdm_mgmt dut (.clock_i, .resetn_i, .mdc_i(mdc), .mdio_i(line), .mdio_o, .mdio_oen_o(oen));
  function automatic logic [15:0] want(mdm_hdr_s a);
    if (a.phy[PATH_BIT]) return {8'h00, er[{a.phy[4:3], a.reg_idx}]};
    return a.reg_idx < PHY_REG_CNT ? sr[a.reg_idx] : 16'h0000;
  endfunction
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value rdata exp %h got %h", e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #5000000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h7854));
    repeat (12) @(posedge clock_i);
    #7 resetn_i = 1'b1;
    for (int k = 0; k < 40; k++) begin
      h = {OP_WRITE, 10'($urandom)};
      d = 16'($urandom);
      case (k)
        0: h[9:0] = 10'h3FF;
        1: h[9:0] = 10'h305;
        2: h[9:0] = 10'h080;
        default: if (!h.phy[PATH_BIT]) h.reg_idx[4:3] = 2'h0;
      endcase
      @(posedge clock_i);
      #7 ml.xfer(h, d, q);
      if (h.phy[PATH_BIT]) er[{h.phy[4:3], h.reg_idx}] = d[7:0];
      else if (h.reg_idx < PHY_REG_CNT) sr[h.reg_idx] = d;
      h.op = OP_READ;
      h.phy = h.phy ^ (h.phy[PATH_BIT] ? 5'h03 : 5'h18);
      ml.xfer(h, 16'h0000, q);
      chk(want(h), q);
    end
    report_and_stop;
  end
endmodule
